// ---- hdl/rcr_map.svh ----
// Purpose: Offsets, bit positions, reset values and vectors of the reset cause recorder
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RCR_OFF_PWRCTL 8'h00
`define RCR_OFF_STATUS 8'h01
`define RCR_OFF_CTRL 8'h02

// ----------------------------------------
// Power control bit positions
// ----------------------------------------
`define RCR_BIT_OVF 7
`define RCR_BIT_UNF 6
`define RCR_BIT_WINV 5
`define RCR_BIT_WDT 4
`define RCR_BIT_PIN 3
`define RCR_BIT_INSTR 2
`define RCR_BIT_POR 1
`define RCR_BIT_BROWN 0

// ----------------------------------------
// Core status and control bit positions
// ----------------------------------------
`define RCR_BIT_TMO 4
`define RCR_BIT_PWDN 3
`define RCR_BIT_STKEN 0
`define RCR_BIT_ASLEEP 7

// ----------------------------------------
// Reset values and load patterns
// ----------------------------------------
`define RCR_PWRCTL_POR_VAL 8'h3C
`define RCR_PWRCTL_BROWN_KEEP 8'h32
`define RCR_PWRCTL_BROWN_SET 8'h0C
`define RCR_PWRCTL_BROWN_CHK 8'hCD
`define RCR_CTRL_RST_VAL 1'b1
`define RCR_RESET_VEC 15'h0000
`define RCR_IRQ_VEC 15'h0004

`endif

// ---- hdl/rcr_pkg.sv ----
// Purpose: Types and shared arithmetic of the reset cause recorder
// Assumes: Nothing is imported; users write rcr_pkg::name
// Notes: Program counter is 15 bits wide
`default_nettype none

package rcr_pkg;

  typedef logic [14:0] rcr_pc_t;

  typedef enum logic [0:0] {
    RS_IDLE = 1'b0,
    RS_WAIT_INSTR = 1'b1
  } rcr_rs_state_t;

  // Next program address
  function automatic rcr_pc_t rcr_pc_inc(input rcr_pc_t pc);
    rcr_pc_inc = rcr_pc_t'(pc + 15'h0001);
  endfunction

endpackage

`default_nettype wire

// ---- hdl/rcr_restart.sv ----
// Purpose: Restart address after resets and wake-ups, deferred interrupt vector
// Assumes: Requests are one-cycle pulses, reset wins over wake
// Notes: Vector is taken after the next instruction retires
`include "rcr_map.svh"
`default_nettype none

module rcr_restart (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Requests
  input wire logic reset_take_i,
  input wire logic wake_take_i,
  input wire logic irq_wake_i,
  input wire logic irq_enable_i,
  input wire rcr_pkg::rcr_pc_t pc_i,
  input wire logic instr_done_i,
  // Restart answers
  output logic restart_valid_o,
  output rcr_pkg::rcr_pc_t restart_pc_o,
  output logic vector_take_o,
  output rcr_pkg::rcr_pc_t push_addr_o
);

  rcr_pkg::rcr_rs_state_t state_r;
  rcr_pkg::rcr_rs_state_t state_nxt;
  logic valid_nxt;
  logic vec_nxt;
  rcr_pkg::rcr_pc_t pc_nxt;
  rcr_pkg::rcr_pc_t push_nxt;

  always_comb begin
    state_nxt = state_r;
    valid_nxt = 1'b0;
    vec_nxt = 1'b0;
    pc_nxt = restart_pc_o;
    push_nxt = push_addr_o;
    if (reset_take_i) begin
      valid_nxt = 1'b1;
      pc_nxt = `RCR_RESET_VEC;
      state_nxt = rcr_pkg::RS_IDLE;
    end else if (wake_take_i) begin
      valid_nxt = 1'b1;
      pc_nxt = rcr_pkg::rcr_pc_inc(pc_i);
      if (irq_wake_i && irq_enable_i) begin
        state_nxt = rcr_pkg::RS_WAIT_INSTR;
      end
    end else begin
      case (state_r)
        rcr_pkg::RS_WAIT_INSTR: begin
          if (instr_done_i) begin
            vec_nxt = 1'b1;
            push_nxt = rcr_pkg::rcr_pc_inc(restart_pc_o);
            pc_nxt = `RCR_IRQ_VEC;
            state_nxt = rcr_pkg::RS_IDLE;
          end
        end
        default: begin
          state_nxt = rcr_pkg::RS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= rcr_pkg::RS_IDLE;
      restart_valid_o <= 1'b0;
      vector_take_o <= 1'b0;
      restart_pc_o <= `RCR_RESET_VEC;
      push_addr_o <= `RCR_RESET_VEC;
    end else begin
      state_r <= state_nxt;
      restart_valid_o <= valid_nxt;
      vector_take_o <= vec_nxt;
      restart_pc_o <= pc_nxt;
      push_addr_o <= push_nxt;
    end
  end

endmodule // rcr_restart

`default_nettype wire

// ---- hdl/rcr_rst_sync.sv ----
// Purpose: Releases the asynchronous reset through two flip-flops
// Assumes: rst_n_i active low, asserted without a clock
// Notes: Release takes two clock edges
`default_nettype none

module rcr_rst_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Released reset
  output logic rst_n_o
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      sync_r <= meta_r;
    end
  end

  assign rst_n_o = sync_r;

endmodule // rcr_rst_sync

`default_nettype wire

// ---- hdl/rcr_top.sv ----
// Purpose: Records the cause of each reset and wake-up in sticky flags
// Assumes: Event inputs are one-cycle pulses synchronous to clk_i
// Notes: rst_n_i acts as the power-on reset of the flags
`include "rcr_map.svh"
`default_nettype none

module rcr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Reset and wake sources
  input wire logic por_evt_i,
  input wire logic bor_evt_i,
  input wire logic pin_rst_evt_i,
  input wire logic wdt_timeout_evt_i,
  input wire logic wdt_window_evt_i,
  input wire logic reset_instr_evt_i,
  input wire logic stack_ovf_evt_i,
  input wire logic stack_unf_evt_i,
  input wire logic irq_wake_evt_i,
  // Core state
  input wire logic asleep_i,
  input wire logic global_irq_enable_i,
  input wire rcr_pkg::rcr_pc_t pc_i,
  input wire logic instr_done_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Restart control
  output logic core_reset_o,
  output logic restart_valid_o,
  output rcr_pkg::rcr_pc_t restart_pc_o,
  output logic vector_take_o,
  output rcr_pkg::rcr_pc_t push_addr_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_n;

  rcr_rst_sync u_rst_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rst_n_o(rst_n)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] power_control_reg;
  logic [7:0] pwrctl_nxt;
  logic timeout_status_r;
  logic timeout_status_nxt;
  logic power_down_status_r;
  logic power_down_status_nxt;
  logic stack_reset_enable_r;
  logic [7:0] rdata_nxt;
  logic core_reset_nxt;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire is_por = por_evt_i;
  wire is_bor = bor_evt_i & ~is_por;
  wire any_power = is_por | is_bor;
  wire ovf_rst = stack_ovf_evt_i & stack_reset_enable_r;
  wire unf_rst = stack_unf_evt_i & stack_reset_enable_r;
  wire wdt_run = wdt_timeout_evt_i & ~asleep_i;
  wire wdt_wake = wdt_timeout_evt_i & asleep_i;
  wire irq_wake = irq_wake_evt_i & asleep_i;
  wire reset_take = any_power | pin_rst_evt_i | wdt_run | wdt_window_evt_i
    | reset_instr_evt_i | ovf_rst | unf_rst;
  wire wake_take = (wdt_wake | irq_wake) & ~reset_take;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire hit_pwrctl = addr_i == `RCR_OFF_PWRCTL;
  wire hit_status = addr_i == `RCR_OFF_STATUS;
  wire hit_ctrl = addr_i == `RCR_OFF_CTRL;
  wire pwrctl_wr = wr_i & hit_pwrctl;
  wire ctrl_wr = wr_i & hit_ctrl;
  wire [7:0] pwrctl_base = pwrctl_wr ? wdata_i : power_control_reg;
  wire [7:0] status_view = {3'h0, timeout_status_r, power_down_status_r, 3'h0};
  wire [7:0] ctrl_view = {asleep_i, 6'h00, stack_reset_enable_r};
  wire [7:0] rd_sel = hit_pwrctl ? power_control_reg :
    hit_status ? status_view :
    hit_ctrl ? ctrl_view : 8'h00;

  // ----------------------------------------
  // Power control flags
  // ----------------------------------------
  // Hardware events win over a firmware write in the same cycle
  always_comb begin
    pwrctl_nxt = pwrctl_base;
    if (is_por) begin
      pwrctl_nxt = `RCR_PWRCTL_POR_VAL;
    end else if (is_bor) begin
      pwrctl_nxt = (pwrctl_base & `RCR_PWRCTL_BROWN_KEEP) | `RCR_PWRCTL_BROWN_SET;
    end else begin
      if (ovf_rst) begin
        pwrctl_nxt[`RCR_BIT_OVF] = 1'b1;
      end
      if (unf_rst) begin
        pwrctl_nxt[`RCR_BIT_UNF] = 1'b1;
      end
      if (wdt_window_evt_i) begin
        pwrctl_nxt[`RCR_BIT_WINV] = 1'b0;
      end
      if (wdt_run) begin
        pwrctl_nxt[`RCR_BIT_WDT] = 1'b0;
      end
      if (pin_rst_evt_i) begin
        pwrctl_nxt[`RCR_BIT_PIN] = 1'b0;
      end
      if (reset_instr_evt_i) begin
        pwrctl_nxt[`RCR_BIT_INSTR] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Timeout and power-down status
  // ----------------------------------------
  always_comb begin
    timeout_status_nxt = timeout_status_r;
    power_down_status_nxt = power_down_status_r;
    if (any_power) begin
      timeout_status_nxt = 1'b1;
      power_down_status_nxt = 1'b1;
    end else if (wdt_run) begin
      timeout_status_nxt = 1'b0;
    end else if (wdt_window_evt_i) begin
      timeout_status_nxt = 1'b1;
    end else if (pin_rst_evt_i && asleep_i) begin
      timeout_status_nxt = 1'b1;
      power_down_status_nxt = 1'b0;
    end else if (wdt_wake && !reset_take) begin
      timeout_status_nxt = 1'b0;
      power_down_status_nxt = 1'b0;
    end else if (irq_wake && !reset_take) begin
      timeout_status_nxt = 1'b1;
      power_down_status_nxt = 1'b0;
    end
  end

  assign rdata_nxt = rd_i ? rd_sel : 8'h00;
  assign core_reset_nxt = reset_take;

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_control_reg <= `RCR_PWRCTL_POR_VAL;
      timeout_status_r <= 1'b1;
      power_down_status_r <= 1'b1;
      stack_reset_enable_r <= `RCR_CTRL_RST_VAL;
      rdata_o <= 8'h00;
      core_reset_o <= 1'b0;
    end else begin
      power_control_reg <= pwrctl_nxt;
      timeout_status_r <= timeout_status_nxt;
      power_down_status_r <= power_down_status_nxt;
      if (ctrl_wr) begin
        stack_reset_enable_r <= wdata_i[`RCR_BIT_STKEN];
      end
      rdata_o <= rdata_nxt;
      core_reset_o <= core_reset_nxt;
    end
  end

  // ----------------------------------------
  // Restart address
  // ----------------------------------------
  rcr_restart u_restart (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .reset_take_i(reset_take),
    .wake_take_i(wake_take),
    .irq_wake_i(irq_wake),
    .irq_enable_i(global_irq_enable_i),
    .pc_i(pc_i),
    .instr_done_i(instr_done_i),
    .restart_valid_o(restart_valid_o),
    .restart_pc_o(restart_pc_o),
    .vector_take_o(vector_take_o),
    .push_addr_o(push_addr_o)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_ovf_sets;
    @(posedge clk_i) disable iff (!rst_n)
    stack_ovf_evt_i && stack_reset_enable_r && !any_power
      |=> power_control_reg[`RCR_BIT_OVF] && core_reset_o;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

  property p_unf_sticky;
    @(posedge clk_i) disable iff (!rst_n)
    power_control_reg[`RCR_BIT_UNF] && !any_power && !(pwrctl_wr && !wdata_i[`RCR_BIT_UNF])
      |=> power_control_reg[`RCR_BIT_UNF];
  endproperty
  a_unf_sticky: assert property (p_unf_sticky) else $error("underflow flag lost");

  property p_stack_gate;
    @(posedge clk_i) disable iff (!rst_n)
    (stack_ovf_evt_i || stack_unf_evt_i) && !stack_reset_enable_r && !pwrctl_wr
      && !(any_power || pin_rst_evt_i || wdt_run || wdt_window_evt_i || reset_instr_evt_i)
      |=> !core_reset_o && $stable(power_control_reg);
  endproperty
  a_stack_gate: assert property (p_stack_gate) else $error("stack reset while off");

  property p_window;
    @(posedge clk_i) disable iff (!rst_n)
    wdt_window_evt_i && !any_power
      |=> !power_control_reg[`RCR_BIT_WINV] && timeout_status_r;
  endproperty
  a_window: assert property (p_window) else $error("window flag not cleared");

  property p_wdt_run;
    @(posedge clk_i) disable iff (!rst_n)
    wdt_run && !any_power
      |=> !power_control_reg[`RCR_BIT_WDT] && !timeout_status_r
      && restart_valid_o && restart_pc_o == `RCR_RESET_VEC;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset wrong");

  property p_pin_sleep;
    @(posedge clk_i) disable iff (!rst_n)
    pin_rst_evt_i && asleep_i && !any_power
      |=> !power_control_reg[`RCR_BIT_PIN] && timeout_status_r && !power_down_status_r;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("pin reset in sleep wrong");

  property p_instr;
    @(posedge clk_i) disable iff (!rst_n)
    reset_instr_evt_i && !any_power |=> !power_control_reg[`RCR_BIT_INSTR];
  endproperty
  a_instr: assert property (p_instr) else $error("instruction flag not cleared");

  property p_por;
    @(posedge clk_i) disable iff (!rst_n)
    is_por |=> power_control_reg == `RCR_PWRCTL_POR_VAL
      && timeout_status_r && power_down_status_r;
  endproperty
  a_por: assert property (p_por) else $error("power-on pattern wrong");

  property p_bor;
    @(posedge clk_i) disable iff (!rst_n)
    is_bor |=> (power_control_reg & `RCR_PWRCTL_BROWN_CHK) == `RCR_PWRCTL_BROWN_SET
      && timeout_status_r && power_down_status_r;
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out pattern wrong");

  property p_wdt_wake;
    @(posedge clk_i) disable iff (!rst_n)
    wdt_wake && !reset_take && !pwrctl_wr
      |=> !timeout_status_r && !power_down_status_r && $stable(power_control_reg);
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_irq_wake;
    @(posedge clk_i) disable iff (!rst_n)
    irq_wake && !reset_take && !pwrctl_wr
      |=> timeout_status_r && !power_down_status_r && $stable(power_control_reg)
      && restart_pc_o == rcr_pkg::rcr_pc_inc($past(pc_i));
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake wrong");

  property p_vector;
    @(posedge clk_i) disable iff (!rst_n)
    vector_take_o |-> restart_pc_o == `RCR_IRQ_VEC && $past(instr_done_i);
  endproperty
  a_vector: assert property (p_vector) else $error("vector taken early");

  property p_read;
    @(posedge clk_i) disable iff (!rst_n)
    rd_i && hit_pwrctl |=> rdata_o == $past(power_control_reg);
  endproperty
  a_read: assert property (p_read) else $error("power control read wrong");

  property p_pin_run;
    @(posedge clk_i) disable iff (!rst_n)
    pin_rst_evt_i && !any_power
      |=> !power_control_reg[`RCR_BIT_PIN] && core_reset_o;
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("pin flag not cleared");

  property p_retain;
    @(posedge clk_i) disable iff (!rst_n)
    !pwrctl_wr && !any_power && !ovf_rst && !unf_rst && !wdt_run && !wdt_window_evt_i
      && !pin_rst_evt_i && !reset_instr_evt_i
      |=> $stable(power_control_reg);
  endproperty
  a_retain: assert property (p_retain) else $error("flag changed without cause");

  property p_stack_status;
    @(posedge clk_i) disable iff (!rst_n)
    (ovf_rst || unf_rst) && !any_power && !wdt_run && !wdt_window_evt_i
      && !(pin_rst_evt_i && asleep_i)
      |=> $stable(timeout_status_r) && $stable(power_down_status_r);
  endproperty
  a_stack_status: assert property (p_stack_status) else $error("status moved");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (!rst_n)
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  c_por: cover property (@(posedge clk_i) disable iff (!rst_n) is_por);
  c_wdt_wake: cover property (@(posedge clk_i) disable iff (!rst_n) wdt_wake && !reset_take);
  c_vector: cover property (@(posedge clk_i) disable iff (!rst_n) vector_take_o);
  c_ovf: cover property (@(posedge clk_i) disable iff (!rst_n) ovf_rst);
  c_pin_sleep: cover property (@(posedge clk_i) disable iff (!rst_n) pin_rst_evt_i && asleep_i);

endmodule // rcr_top

`default_nettype wire

// ---- test/rcr_src_model.sv ----
// Purpose: Reset and wake sources seen from the recorder: one-cycle event pulses
// Assumes: Bit order por, bor, pin, wdt timeout, window, instr, ovf, unf, irq wake
// Notes: Pulses launch right after an edge and drop at the edge that samples them
`default_nettype none

module rcr_src_model (
  // Clock
  input wire logic clk_i,
  // Event pulses
  output var logic [8:0] evt_o
);
  initial evt_o = 9'h000;

  // ----------------------------------------
  // Pulse driver
  // ----------------------------------------
  // One cycle high, returns at the sampling edge
  task automatic fire(input logic [8:0] m);
    @(posedge clk_i);
    evt_o <= m;
    @(posedge clk_i);
    evt_o <= 9'h000;
  endtask
endmodule // rcr_src_model

`default_nettype wire

// ---- test/rcr_top_tb.sv ----
// Purpose: Self-checking bench of the reset cause recorder
// Assumes: Events from rcr_src_model, register port driven here
// Notes: Undefined brown-out bit after power-on taken as 0
`include "rcr_map.svh"
`default_nettype none

module rcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, asleep, irq_en, instr_done, wr, rd, core_rst, rvalid, vtake;
  logic [7:0] addr, wdata, rdata;
  logic [8:0] evt;
  rcr_pkg::rcr_pc_t pc, rpc, push;
  int miscompares, n_tests;

  rcr_src_model src (.clk_i(clk), .evt_o(evt));

  rcr_top dut (
    .clk_i(clk), .rst_n_i(rst_n),
    .por_evt_i(evt[0]), .bor_evt_i(evt[1]), .pin_rst_evt_i(evt[2]),
    .wdt_timeout_evt_i(evt[3]), .wdt_window_evt_i(evt[4]), .reset_instr_evt_i(evt[5]),
    .stack_ovf_evt_i(evt[6]), .stack_unf_evt_i(evt[7]), .irq_wake_evt_i(evt[8]),
    .asleep_i(asleep), .global_irq_enable_i(irq_en), .pc_i(pc), .instr_done_i(instr_done),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .core_reset_o(core_rst), .restart_valid_o(rvalid), .restart_pc_o(rpc),
    .vector_take_o(vtake), .push_addr_o(push)
  );

  // ----------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run;
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus_rd(a, d);
    chk(what, {8'h00, d}, {8'h00, e});
  endtask

  // One event, then reset pulse, restart address and both flag registers
  task automatic do_evt(input logic [8:0] m, input logic asl, input logic g,
                        input logic [7:0] ep, input logic [7:0] es, input logic er,
                        input logic act, input logic [14:0] epc);
    int i;
    @(posedge clk);
    asleep <= asl;
    irq_en <= g;
    src.fire(m);
    #1;
    chk("core_reset", {15'h0000, core_rst}, {15'h0000, er});
    if (act) begin
      i = 0;
      while (rvalid !== 1'b1 && i < 4) begin
        @(posedge clk);
        #1;
        i++;
      end
      chk("restart_valid", {15'h0000, rvalid}, 16'h0001);
      chk("restart_pc", {1'b0, rpc}, {1'b0, epc});
    end
    chk_reg("power_control", `RCR_OFF_PWRCTL, ep);
    chk_reg("core_status", `RCR_OFF_STATUS, es);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    chk_reg("pwrctl_por", `RCR_OFF_PWRCTL, 8'h3C);
    chk_reg("status_por", `RCR_OFF_STATUS, 8'h18);
    chk_reg("ctrl_por", `RCR_OFF_CTRL, 8'h01);
    @(posedge clk);
    #1;
    chk("rdata_idle", {8'h00, rdata}, 16'h0000);
    chk_reg("unmapped", 8'h05, 8'h00);
    bus_wr(`RCR_OFF_STATUS, 8'h00);
    chk_reg("status_ro", `RCR_OFF_STATUS, 8'h18);
    bus_wr(`RCR_OFF_PWRCTL, 8'h3F);
    chk_reg("pwrctl_rearm", `RCR_OFF_PWRCTL, 8'h3F);
  endtask

  // Every reset source from a rearmed register, running
  task automatic t_sources;
    logic [8:0] m [8] = '{9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h002, 9'h001};
    logic [7:0] ep [8] = '{8'h37, 8'h2F, 8'h1F, 8'h3B, 8'hBF, 8'h7F, 8'h3E, 8'h3C};
    logic [7:0] es [8] = '{8'h18, 8'h08, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18};
    for (int k = 0; k < 8; k++) begin
      bus_wr(`RCR_OFF_PWRCTL, 8'h3F);
      do_evt(m[k], 1'b0, 1'b0, ep[k], es[k], 1'b1, 1'b1, 15'h0000);
    end
  endtask

  // Stack resets refused while disabled
  task automatic t_stack_off;
    bus_wr(`RCR_OFF_CTRL, 8'h00);
    chk_reg("ctrl_off", `RCR_OFF_CTRL, 8'h00);
    do_evt(9'h040, 1'b0, 1'b0, 8'h3C, 8'h18, 1'b0, 1'b0, 15'h0000);
    do_evt(9'h080, 1'b0, 1'b0, 8'h3C, 8'h18, 1'b0, 1'b0, 15'h0000);
    bus_wr(`RCR_OFF_CTRL, 8'h01);
  endtask

  // Wakes and pin reset while asleep, then deferred vector
  task automatic t_sleep;
    int i;
    @(posedge clk);
    pc <= 15'h0123;
    do_evt(9'h008, 1'b1, 1'b0, 8'h3C, 8'h00, 1'b0, 1'b1, 15'h0124);
    do_evt(9'h004, 1'b1, 1'b0, 8'h34, 8'h10, 1'b1, 1'b1, 15'h0000);
    do_evt(9'h001, 1'b0, 1'b0, 8'h3C, 8'h18, 1'b1, 1'b1, 15'h0000);
    do_evt(9'h100, 1'b1, 1'b0, 8'h3C, 8'h10, 1'b0, 1'b1, 15'h0124);
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    #1;
    chk("no_vector", {15'h0000, vtake}, 16'h0000);
    do_evt(9'h100, 1'b1, 1'b1, 8'h3C, 8'h10, 1'b0, 1'b1, 15'h0124);
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    #1;
    i = 0;
    while (vtake !== 1'b1 && i < 4) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("vector_take", {15'h0000, vtake}, 16'h0001);
    chk("vector_pc", {1'b0, rpc}, 16'h0004);
    chk("push_addr", {1'b0, push}, 16'h0125);
    @(posedge clk);
    asleep <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    miscompares = 0;
    n_tests = 0;
    rst_n = 1'b0;
    asleep = 1'b0;
    irq_en = 1'b0;
    instr_done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pc = 15'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_vals();
    t_sources();
    t_stack_off();
    t_sleep();
    complete_run();
  end
endmodule // rcr_top_tb

`default_nettype wire
